/* clkr_pkg.sv */
// Shared constants for the clock ratio and GO controller
package clkr_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;
    localparam int NDIV = 16;
    localparam int MULT_W = 6;
    localparam int RATIO_W = 5;
    localparam int NDIV_LOW = 3;

    localparam logic [8:0] OFS_CTL = 9'h100;
    localparam logic [8:0] OFS_MULT = 9'h110;
    localparam logic [8:0] OFS_REFERENCE_PRE_DIVIDER = 9'h114;
    localparam logic [8:0] OFS_DIV1 = 9'h118;
    localparam logic [8:0] OFS_DIV3 = 9'h120;
    localparam logic [8:0] OFS_CMD = 9'h138;
    localparam logic [8:0] OFS_STAT = 9'h13c;
    localparam logic [8:0] OFS_CHG = 9'h144;
    localparam logic [8:0] OFS_DIV4 = 9'h160;
    localparam logic [8:0] OFS_DIV16 = 9'h190;

    localparam int EN_BIT = 15;
    localparam int GO_BIT = 0;
    localparam int BUSY_BIT = 0;
    localparam int LOOP_BIT = 0;
    localparam int CTL_ONE_BIT = 6;

    localparam logic LOOP_RST = 1'b0;
    localparam logic [5:0] MULT_RST = 6'h00;
    localparam logic PRE_EN_RST = 1'b1;
    localparam logic [4:0] PRE_RATIO_RST = 5'h00;
    localparam logic DIV_EN_RST = 1'b1;
    localparam logic [4:0] DIV_RATIO_RST = 5'h00;

    // Reference clock is one tick per this many mclk cycles
    localparam int REF_PERIOD = 64;

    typedef enum logic [1:0] {
        GO_IDLE,
        GO_ARM,
        GO_WAIT
    } clkr_go_e;
endpackage

/* clkr_rate_gen.sv */
// Reference tick, loop rate model and bypass select
`timescale 1ns/10ps
`default_nettype none
module clkr_rate_gen
    import clkr_pkg::*;
#(
    parameter int REF_P = REF_PERIOD
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic loop_path_select,
    input wire logic [MULT_W-1:0] freq_multiplier,
    input wire logic pre_divider_enable,
    input wire logic [RATIO_W-1:0] pre_ratio,
    output logic src_tick
);
    localparam int ACC_W = $clog2(REF_P * 32) + 2;
    localparam int CNT_W = $clog2(REF_P) + 1;

    typedef struct packed {
        logic [CNT_W-1:0] ref_cnt;
        logic [ACC_W-1:0] acc;
        logic tick;
    } clkr_rg_s;

    clkr_rg_s r, next_r;
    logic ref_tick;
    logic [ACC_W-1:0] thr;
    logic [ACC_W-1:0] sum;
    logic loop_tick;

    assign src_tick = r.tick;

    always_comb begin
        next_r = r;
        ref_tick = (r.ref_cnt == CNT_W'(REF_P - 1));
        next_r.ref_cnt = ref_tick ? '0 : r.ref_cnt + 1'b1;
        // Loop rate = reference * (mult+1) / (ratio+1), kept as pulse density
        thr = ACC_W'(REF_P * (32'(pre_ratio) + 32'd1));
        sum = r.acc + ACC_W'(freq_multiplier) + 1'b1;
        loop_tick = 1'b0;
        if (!pre_divider_enable) begin
            next_r.acc = '0;
        end else if (sum >= thr) begin
            next_r.acc = sum - thr;
            loop_tick = 1'b1;
        end else begin
            next_r.acc = sum;
        end
        next_r.tick = loop_path_select ? loop_tick : ref_tick;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule
`default_nettype wire

/* clkr_out_div.sv */
// One output divider with ratio swap at a period boundary or while disabled
`timescale 1ns/10ps
`default_nettype none
module clkr_out_div
    import clkr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic src_tick,
    input wire logic enable,
    input wire logic [RATIO_W-1:0] ratio_new,
    input wire logic apply,
    output logic clk_tick,
    output logic busy
);
    typedef struct packed {
        logic [RATIO_W-1:0] cnt;
        logic [RATIO_W-1:0] ratio_act;
        logic [RATIO_W-1:0] staged;
        logic pending;
        logic tick;
    } clkr_od_s;

    clkr_od_s r, next_r;
    logic wrap;

    assign clk_tick = r.tick;
    assign busy = r.pending;

    always_comb begin
        next_r = r;
        wrap = src_tick && (r.cnt == r.ratio_act);
        next_r.tick = enable && wrap;
        if (!enable) begin
            next_r.cnt = '0;
        end else if (src_tick) begin
            next_r.cnt = wrap ? '0 : r.cnt + 1'b1;
        end
        // Swap at a period boundary, or at once while disabled, so no short pulse escapes
        if (r.pending && (!enable || wrap)) begin
            next_r.ratio_act = r.staged;
            next_r.cnt = '0;
            next_r.pending = 1'b0;
        end
        if (apply) begin
            next_r.staged = ratio_new;
            next_r.pending = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '{cnt: '0, ratio_act: DIV_RATIO_RST, staged: DIV_RATIO_RST, pending: 1'b0, tick: 1'b0};
        end else begin
            r <= next_r;
        end
    end
endmodule
`default_nettype wire

/* clkr_ctrl.sv */
// Clock ratio registers, GO sequencer and sixteen output dividers
//
// How it works
// - Multiplier field value plus one scales reference.
// - Loop rate is reference times multiplier over predivide.
// - Pre-divider enable low gates loop output.
// - Pre-divide ratio field plus one divides reference.
// - Divider enable low stops that system clock.
// - Each divider divides by ratio plus one.
// - Reserved bits read zero, writes ignored; control word bit 6 always reads one.
// - Writing one to command bit starts GO.
// - Command bit holds; each one-write restarts GO.
// - Loop select low bypasses pre-divider and loop.
// - Status bit zero shows GO in progress.
// - Different ratio sets flag; GO updates flagged only.
`timescale 1ns/10ps
`default_nettype none
module clkr_ctrl
    import clkr_pkg::*;
#(
    parameter int REF_P = REF_PERIOD
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [NDIV-1:0] system_clock_n,
    output logic ratio_change_in_progress
);
    typedef logic [NDIV-1:0][RATIO_W-1:0] clkr_ratio_t;

    typedef struct packed {
        logic waitreq;
        logic [DATA_W-1:0] rdata;
        logic loop_path_select;
        logic [MULT_W-1:0] freq_multiplier;
        logic pre_en;
        logic [RATIO_W-1:0] pre_ratio;
        logic [NDIV-1:0] div_en;
        clkr_ratio_t div_ratio;
        logic ratio_change_command;
        logic [NDIV-1:0] ratio_modified_flags;
        logic [NDIV-1:0] go_mask;
        logic [NDIV-1:0] apply;
        logic busy;
        clkr_go_e go_state;
    } clkr_ctrl_s;

    clkr_ctrl_s r, next_r;

    logic src_tick;
    logic [NDIV-1:0] div_busy;
    logic [NDIV-1:0] div_tick;

    // Decoded access of the current bus cycle
    logic acc_ok;
    logic wr_ok;
    logic rd_ok;
    logic [4:0] slot;
    logic slot_hit;
    logic [RATIO_W-1:0] wr_ratio;
    logic [NDIV-1:0] chg_set;
    logic go_start;
    logic [DATA_W-1:0] rd_word;

    // Map a byte address onto a divider index; miss flag in the top bit
    function automatic logic [4:0] div_slot(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = '0;
        div_slot = 5'h10;
        if (a[1:0] == 2'h0) begin
            if (a >= OFS_DIV1 && a <= OFS_DIV3) begin
                d = a - OFS_DIV1;
                div_slot = {1'b0, d[5:2]};
            end else if (a >= OFS_DIV4 && a <= OFS_DIV16) begin
                d = a - OFS_DIV4;
                div_slot = {1'b0, 4'(d[5:2] + 4'(NDIV_LOW))};
            end
        end
    endfunction

    assign avs_waitrequest = r.waitreq;
    assign avs_readdata = r.rdata;
    assign ratio_change_in_progress = r.busy;
    assign system_clock_n = div_tick;

    clkr_rate_gen #(
        .REF_P(REF_P)
    ) u_rate (
        .mclk(mclk),
        .rst(rst),
        .loop_path_select(r.loop_path_select),
        .freq_multiplier(r.freq_multiplier),
        .pre_divider_enable(r.pre_en),
        .pre_ratio(r.pre_ratio),
        .src_tick(src_tick)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NDIV; gi++) begin : g_div
            clkr_out_div u_div (
                .mclk(mclk),
                .rst(rst),
                .src_tick(src_tick),
                .enable(r.div_en[gi]),
                .ratio_new(r.div_ratio[gi]),
                .apply(r.apply[gi]),
                .clk_tick(div_tick[gi]),
                .busy(div_busy[gi])
            );
        end
    endgenerate

    // Read word assembly; unlisted bits stay zero
    always_comb begin
        rd_word = '0;
        slot = div_slot(avs_address);
        slot_hit = !slot[4];
        if (slot_hit) begin
            rd_word[EN_BIT] = r.div_en[slot[3:0]];
            rd_word[RATIO_W-1:0] = r.div_ratio[slot[3:0]];
        end else begin
            unique case (avs_address)
                OFS_CTL: begin
                    rd_word[LOOP_BIT] = r.loop_path_select;
                    rd_word[CTL_ONE_BIT] = 1'b1;
                end
                OFS_MULT: begin
                    rd_word[MULT_W-1:0] = r.freq_multiplier;
                end
                OFS_REFERENCE_PRE_DIVIDER: begin
                    rd_word[EN_BIT] = r.pre_en;
                    rd_word[RATIO_W-1:0] = r.pre_ratio;
                end
                OFS_CMD: begin
                    rd_word[GO_BIT] = r.ratio_change_command;
                end
                OFS_STAT: begin
                    rd_word[BUSY_BIT] = r.busy;
                end
                OFS_CHG: begin
                    rd_word[NDIV-1:0] = r.ratio_modified_flags;
                end
                default: begin
                    rd_word = '0;
                end
            endcase
        end
    end

    always_comb begin
        next_r = r;
        // Each request gets exactly one waitrequest-low cycle
        acc_ok = (avs_read || avs_write) && !r.waitreq;
        wr_ok = avs_write && !r.waitreq;
        rd_ok = avs_read && !r.waitreq;
        next_r.waitreq = !((avs_read || avs_write) && r.waitreq);
        if ((avs_read || avs_write) && r.waitreq) begin
            next_r.rdata = avs_read ? rd_word : '0;
        end
        wr_ratio = avs_writedata[RATIO_W-1:0];
        chg_set = '0;
        go_start = 1'b0;
        next_r.apply = '0;

        if (wr_ok) begin
            if (slot_hit) begin
                if (avs_byteenable[0]) begin
                    next_r.div_ratio[slot[3:0]] = wr_ratio;
                    if (wr_ratio != r.div_ratio[slot[3:0]]) begin
                        chg_set[slot[3:0]] = 1'b1;
                    end
                end
                if (avs_byteenable[1]) begin
                    next_r.div_en[slot[3:0]] = avs_writedata[EN_BIT];
                end
            end else begin
                unique case (avs_address)
                    OFS_CTL: begin
                        if (avs_byteenable[0]) begin
                            next_r.loop_path_select = avs_writedata[LOOP_BIT];
                        end
                    end
                    OFS_MULT: begin
                        if (avs_byteenable[0]) begin
                            next_r.freq_multiplier = avs_writedata[MULT_W-1:0];
                        end
                    end
                    OFS_REFERENCE_PRE_DIVIDER: begin
                        if (avs_byteenable[0]) begin
                            next_r.pre_ratio = wr_ratio;
                        end
                        if (avs_byteenable[1]) begin
                            next_r.pre_en = avs_writedata[EN_BIT];
                        end
                    end
                    OFS_CMD: begin
                        if (avs_byteenable[0]) begin
                            next_r.ratio_change_command = avs_writedata[GO_BIT];
                            go_start = avs_writedata[GO_BIT];
                        end
                    end
                    default: begin
                        // Status, flags and unmapped words ignore writes
                        next_r.rdata = next_r.rdata;
                    end
                endcase
            end
        end

        // GO sequencer; a new start simply restarts it
        unique case (r.go_state)
            GO_IDLE: begin
                next_r.busy = 1'b0;
            end
            GO_ARM: begin
                // Dividers see apply this cycle; their busy shows next
                next_r.go_state = GO_WAIT;
            end
            GO_WAIT: begin
                if ((div_busy & r.go_mask) == '0) begin
                    next_r.ratio_modified_flags = r.ratio_modified_flags & ~r.go_mask;
                    next_r.busy = 1'b0;
                    next_r.go_state = GO_IDLE;
                end
            end
        endcase

        if (go_start) begin
            next_r.go_mask = r.ratio_modified_flags;
            next_r.apply = r.ratio_modified_flags;
            next_r.busy = 1'b1;
            next_r.go_state = GO_ARM;
        end

        // A ratio write landing with GO completion keeps its flag
        next_r.ratio_modified_flags = next_r.ratio_modified_flags | chg_set;
        if (rd_ok) begin
            next_r.rdata = r.rdata;
        end
        if (acc_ok && !avs_read && !avs_write) begin
            next_r.waitreq = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r.waitreq <= 1'b1;
            r.rdata <= '0;
            r.loop_path_select <= LOOP_RST;
            r.freq_multiplier <= MULT_RST;
            r.pre_en <= PRE_EN_RST;
            r.pre_ratio <= PRE_RATIO_RST;
            r.div_en <= {NDIV{DIV_EN_RST}};
            r.div_ratio <= {NDIV{DIV_RATIO_RST}};
            r.ratio_change_command <= 1'b0;
            r.ratio_modified_flags <= '0;
            r.go_mask <= '0;
            r.apply <= '0;
            r.busy <= 1'b0;
            r.go_state <= GO_IDLE;
        end else begin
            r <= next_r;
        end
    end
endmodule
`default_nettype wire

/* placeholder_none.sv */
// Intentionally empty: no further design content
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* clkr_ctrl_sva.sv */
// Port assertions for the clock ratio and GO controller
`timescale 1ns/10ps
`default_nettype none
module clkr_ctrl_sva
    import clkr_pkg::*;
#(
    parameter int REF_P = REF_PERIOD
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [NDIV-1:0] system_clock_n,
    input wire logic ratio_change_in_progress
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence taken_s;
        (avs_read || avs_write) && !avs_waitrequest;
    endsequence
    sequence rd_s(logic [8:0] a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence
    sequence go_s;
        avs_write && !avs_waitrequest && avs_address == OFS_CMD && avs_byteenable[0] && avs_writedata[GO_BIT];
    endsequence
    wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    wait_single_a: assert property (taken_s |=> avs_waitrequest)
        else $error("waitrequest low too long");
    idle_wait_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer without request");
    write_zero_a: assert property (avs_write && !avs_waitrequest |-> avs_readdata == '0)
        else $error("read data not zero on write");
    mult_resv_a: assert property (rd_s(OFS_MULT) |-> avs_readdata[31:6] == '0)
        else $error("multiplier reserved bits set");
    div_resv_a: assert property (rd_s(OFS_DIV1) |-> avs_readdata[31:16] == '0 && avs_readdata[14:5] == '0)
        else $error("divider reserved bits set");
    cmd_resv_a: assert property (rd_s(OFS_CMD) |-> avs_readdata[31:1] == '0)
        else $error("command reserved bits set");
    go_busy_a: assert property (go_s |=> ratio_change_in_progress [*2])
        else $error("busy not raised by GO");
    go_only_a: assert property ($rose(ratio_change_in_progress) |-> $past(avs_write && !avs_waitrequest && avs_address == OFS_CMD && avs_byteenable[0] && avs_writedata[GO_BIT]))
        else $error("busy raised without GO write");
endmodule
bind clkr_ctrl clkr_ctrl_sva #(.REF_P(REF_P)) clkr_ctrl_sva_inst (.mclk(mclk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .system_clock_n(system_clock_n), .ratio_change_in_progress(ratio_change_in_progress));
`default_nettype wire

/* tb_clock_ratio_and_go_control.sv */
// Self-checking bench for the clock ratio and GO controller
`timescale 1ns/10ps
`default_nettype none
module tb_clock_ratio_and_go_control;
    import clkr_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [NDIV-1:0] system_clock_n;
    logic ratio_change_in_progress;
    int mismatches = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'h70ba;
    logic [31:0] q;
    logic [31:0] v;
    logic [4:0] ratio [NDIV];
    logic [15:0] flags = '0;
    int p, m, pr, e;

    clkr_ctrl clkr_ctrl_inst (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .system_clock_n(system_clock_n),
        .ratio_change_in_progress(ratio_change_in_progress));

    initial begin
        forever #20 mclk = ~mclk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [8:0] dadr(input int i);
        return (i < NDIV_LOW) ? OFS_DIV1 + 9'(4 * i) : OFS_DIV4 + 9'(4 * (i - NDIV_LOW));
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50) mismatches++;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rdchk(input logic [8:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        chk(q, x);
    endtask

    task automatic setdiv(input int i, input logic [31:0] d);
        if (d[4:0] != ratio[i]) flags[i] = 1'b1;
        ratio[i] = d[4:0];
        bus(1'b1, dadr(i), d);
        rdchk(dadr(i), d & 32'h801f);
        rdchk(OFS_CHG, {16'h0, flags});
    endtask

    task automatic go();
        int n;
        n = 0;
        rdchk(OFS_STAT, 32'h0);
        bus(1'b1, OFS_CMD, 32'h1);
        chk(32'(ratio_change_in_progress), 32'h1);
        while (ratio_change_in_progress !== 1'b0 && n < 6000) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 6000) mismatches++;
        flags = '0;
        rdchk(OFS_CHG, 32'h0);
        rdchk(OFS_STAT, 32'h0);
        rdchk(OFS_CMD, 32'h1);
    endtask

    task automatic cnt(input int i, input int w, output int c);
        c = 0;
        repeat (w) begin
            @(posedge mclk);
            if (system_clock_n[i] === 1'b1) c++;
        end
    endtask

    // Pulse-to-pulse distance, bounded so a dead divider cannot hang
    task automatic per(input int i, output int c);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (system_clock_n[i] !== 1'b1 && n < 5000);
        c = 0;
        do begin
            @(posedge mclk);
            c++;
        end while (system_clock_n[i] !== 1'b1 && c < 5000);
    endtask

    initial begin
        repeat (90000) @(posedge mclk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rdchk(OFS_CTL, 32'h40);
        rdchk(OFS_MULT, 32'h0);
        rdchk(OFS_REFERENCE_PRE_DIVIDER, 32'h8000);
        rdchk(OFS_CMD, 32'h0);
        for (int i = 0; i < NDIV; i++) begin
            ratio[i] = '0;
            rdchk(dadr(i), 32'h8000);
        end
        bus(1'b1, 9'h104, '1);
        rdchk(9'h104, 32'h0);
        bus(1'b1, OFS_CHG, '1);
        rdchk(OFS_CHG, 32'h0);
        for (int k = 0; k < 4; k++) begin
            v = rnd();
            bus(1'b1, OFS_MULT, v);
            rdchk(OFS_MULT, v & 32'h3f);
            bus(1'b1, OFS_REFERENCE_PRE_DIVIDER, v);
            rdchk(OFS_REFERENCE_PRE_DIVIDER, v & 32'h801f);
            bus(1'b1, OFS_CMD, v & 32'hfffffffe);
            rdchk(OFS_CMD, 32'h0);
        end
        avs_byteenable <= 4'h2;
        bus(1'b1, OFS_MULT, ~v);
        avs_byteenable <= 4'hf;
        rdchk(OFS_MULT, v & 32'h3f);
        $display("test registers done");
        for (int i = 0; i < NDIV; i++) setdiv(i, rnd() | 32'h8000);
        go();
        for (int k = 0; k < 2; k++) begin
            per(15 * k, p);
            chk(32'(p), 32'((ratio[15 * k] + 1) * REF_PERIOD));
        end
        setdiv(0, 32'h801f);
        setdiv(15, 32'h8000);
        setdiv(1, {27'h0, ratio[1]});
        go();
        per(0, p);
        chk(32'(p), 32'(32 * REF_PERIOD));
        per(15, p);
        chk(32'(p), 32'(REF_PERIOD));
        cnt(1, 2200, p);
        chk(32'(p), 32'h0);
        bus(1'b1, OFS_CMD, 32'h0);
        rdchk(OFS_CMD, 32'h0);
        go();
        go();
        $display("test go done");
        setdiv(0, 32'h8000);
        go();
        bus(1'b1, OFS_CTL, 32'h1);
        for (int k = 0; k < 4; k++) begin
            m = (k == 0) ? 63 : int'(rnd() % 64);
            pr = (k == 0) ? 0 : int'(rnd() % 32);
            bus(1'b1, OFS_MULT, 32'(m));
            bus(1'b1, OFS_REFERENCE_PRE_DIVIDER, 32'h8000 | 32'(pr));
            cnt(0, 1024, p);
            e = 16 * (m + 1) / (pr + 1);
            chk(32'(p >= e - 2 && p <= e + 2), 32'h1);
        end
        // Pre-divider off leaves the loop with no source at all
        bus(1'b1, OFS_REFERENCE_PRE_DIVIDER, 32'(pr));
        cnt(0, 8, p);
        cnt(0, 1024, p);
        chk(32'(p), 32'h0);
        bus(1'b1, OFS_CTL, 32'h0);
        cnt(0, 1024, p);
        chk(32'(p >= 15 && p <= 17), 32'h1);
        $display("test loop done");
        // Mid-run reset must restore control, multiplier, pre-divider, command, flags, divider 0 and divider 3's period
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rdchk(OFS_CTL, 32'h40);
        rdchk(OFS_MULT, 32'h0);
        rdchk(OFS_REFERENCE_PRE_DIVIDER, 32'h8000);
        rdchk(OFS_CMD, 32'h0);
        rdchk(OFS_CHG, 32'h0);
        rdchk(dadr(0), 32'h8000);
        per(3, p);
        chk(32'(p), 32'(REF_PERIOD));
        $display("test reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
